// ===== rtl/sar_ctrl_pkg.sv
package sar_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_INPUT_SELECT = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_A    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_B    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RESULT_LOW   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH  = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int IS_CH_LSB    = 0;
    localparam int IS_ALIGN_BIT = 5;
    localparam int IS_REF_LSB   = 6;
    localparam int CA_PS_LSB    = 0;
    localparam int CA_FLAG_BIT  = 4;
    localparam int CA_AUTO_BIT  = 5;
    localparam int CA_START_BIT = 6;
    localparam int CA_EN_BIT    = 7;
    localparam int CB_TS_LSB    = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and codes
    localparam int RESULT_W = 10;
    localparam int CH_W     = 4;
    localparam int REF_W    = 2;
    localparam int PS_W     = 3;
    localparam int TS_W     = 3;
    localparam int PCNT_W   = 7;
    localparam int LEFT_W   = 5;

    localparam logic [TS_W-1:0]  TRIG_FREE_RUN  = 3'h0;
    localparam logic [REF_W-1:0] REF_PIN        = 2'h0;
    localparam logic [REF_W-1:0] REF_SUPPLY     = 2'h1;
    localparam logic [REF_W-1:0] REF_INTERNAL   = 2'h3;
    localparam logic [CH_W-1:0]  CH_BANDGAP     = 4'hE;
    localparam logic [CH_W-1:0]  CH_GROUND      = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and cycle counts
    localparam logic [7:0]        RESET_BYTE    = 8'h00;
    localparam logic [LEFT_W-1:0] NORMAL_CYCLES = 5'h0D;
    localparam logic [LEFT_W-1:0] FIRST_CYCLES  = 5'h19;
    localparam logic [LEFT_W-1:0] LAST_CYCLE    = 5'h01;

    typedef enum logic {conv_idle, conv_run} conv_state_t;

endpackage : sar_ctrl_pkg

// ===== rtl/conv_prescaler.sv
`timescale 1ns/1ns
module conv_prescaler (
    input  wire logic                           clk_i,
    input  wire logic                           reset_n_i,
    input  wire logic                           enable_i,
    input  wire logic                           restart_i,
    input  wire logic [sar_ctrl_pkg::PS_W-1:0]  div_sel_i,
    output logic                                tick_o
);
    import sar_ctrl_pkg::*;

    typedef struct packed {
        logic [PCNT_W-1:0] cnt;
        logic              tick;
    } presc_state_t;

    presc_state_t s;
    presc_state_t next_s;
    logic [PCNT_W-1:0] limit;

    always_comb begin
        next_s = s;
        if (div_sel_i == '0) begin
            limit = 7'h01;
        end else begin
            limit = PCNT_W'((8'h01 << div_sel_i) - 8'h01);
        end
        if (!enable_i || restart_i) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b0;
        end else if (s.cnt == limit) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt  = s.cnt + 7'h01;
            next_s.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;

endmodule : conv_prescaler

// ===== rtl/trigger_edge.sv
`timescale 1ns/1ns
module trigger_edge (
    input  wire logic                           clk_i,
    input  wire logic                           reset_n_i,
    input  wire logic [7:0]                     sources_i,
    input  wire logic [sar_ctrl_pkg::TS_W-1:0]  sel_i,
    output logic                                rise_o
);
    import sar_ctrl_pkg::*;

    typedef struct packed {
        logic prev;
        logic rise;
    } edge_state_t;

    edge_state_t s;
    edge_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.prev = sources_i[sel_i];
        next_s.rise = sources_i[sel_i] & ~s.prev;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise_o = s.rise;

endmodule : trigger_edge

// ===== rtl/sar_converter_control.sv
`timescale 1ns/1ns
module sar_converter_control (
    input  wire logic                               clk_i,
    input  wire logic                               reset_n_i,
    input  wire logic                               psel_i,
    input  wire logic                               penable_i,
    input  wire logic                               pwrite_i,
    input  wire logic [sar_ctrl_pkg::ADDR_W-1:0]    paddr_i,
    input  wire logic [sar_ctrl_pkg::DATA_W-1:0]    pwdata_i,
    output logic      [sar_ctrl_pkg::DATA_W-1:0]    prdata_o,
    output logic                                    pready_o,
    output logic                                    pslverr_o,
    input  wire logic [7:1]                         trigger_i,
    input  wire logic [sar_ctrl_pkg::RESULT_W-1:0]  result_data_i,
    output logic                                    converter_on_o,
    output logic                                    converting_o,
    output logic      [sar_ctrl_pkg::CH_W-1:0]      channel_o,
    output logic      [sar_ctrl_pkg::REF_W-1:0]     reference_o
);
    import sar_ctrl_pkg::*;

    typedef struct packed {
        conv_state_t           state;
        logic [LEFT_W-1:0]     left;
        logic                  first;
        logic                  enable;
        logic                  auto_trig;
        logic                  flag;
        logic [PS_W-1:0]       ps;
        logic [TS_W-1:0]       tsel;
        logic [REF_W-1:0]      ref_w;
        logic                  align;
        logic [CH_W-1:0]       ch_w;
        logic [REF_W-1:0]      app_ref;
        logic [CH_W-1:0]       app_ch;
        logic [RESULT_W-1:0]   result;
        logic                  lock;
        logic                  pready;
        logic                  pslverr;
        logic [DATA_W-1:0]     prdata;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic        tick;
    logic        trig_rise;
    logic        presc_restart;
    logic        done;
    logic        free_run;
    logic        sw_start;
    logic        apb_setup;
    logic        apb_acc;
    logic        hit;
    logic [15:0] aligned;

    ////////////////////////////////////////////////////////////////////////////
    // Result placement over the two bytes
    function automatic logic [15:0] align_result(input logic [RESULT_W-1:0] raw,
                                                 input logic                left);
        if (left) begin
            align_result = {raw, 6'h00};
        end else begin
            align_result = {6'h00, raw};
        end
    endfunction : align_result

    function automatic logic [DATA_W-1:0] read_word(input ctrl_state_t  st,
                                                    input logic [ADDR_W-1:0] a);
        logic [15:0] al;
        al        = align_result(st.result, st.align);
        read_word = '0;
        unique case (a)
            OFS_INPUT_SELECT: read_word[7:0] = {st.ref_w, st.align, 1'b0, st.ch_w};
            OFS_CONTROL_A:    read_word[7:0] = {st.enable, st.state == conv_run,
                                                st.auto_trig, st.flag, 1'b0, st.ps};
            OFS_CONTROL_B:    read_word[7:0] = {5'h00, st.tsel};
            OFS_RESULT_LOW:   read_word[7:0] = al[7:0];
            OFS_RESULT_HIGH:  read_word[7:0] = al[15:8];
            default:          read_word      = '0;
        endcase
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////
    // Converter clock and trigger
    conv_prescaler u_prescaler (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .enable_i  (s.enable),
        .restart_i (presc_restart),
        .div_sel_i (s.ps),
        .tick_o    (tick)
    );

    trigger_edge u_trigger (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .sources_i ({trigger_i, s.flag}),
        .sel_i     (s.tsel),
        .rise_o    (trig_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    assign apb_setup = psel_i & penable_i & ~s.pready;
    assign apb_acc   = psel_i & penable_i & s.pready;
    assign hit       = (paddr_i == OFS_INPUT_SELECT) || (paddr_i == OFS_CONTROL_A) ||
                       (paddr_i == OFS_CONTROL_B) || (paddr_i == OFS_RESULT_LOW) ||
                       (paddr_i == OFS_RESULT_HIGH);
    assign free_run  = s.auto_trig & (s.tsel == TRIG_FREE_RUN);
    assign done      = (s.state == conv_run) & tick & (s.left == LAST_CYCLE);
    assign sw_start  = apb_acc & pwrite_i & (paddr_i == OFS_CONTROL_A) &
                       pwdata_i[CA_START_BIT];
    // Trigger edge only counts while idle
    assign presc_restart = s.auto_trig & trig_rise & (s.state == conv_idle);
    assign aligned   = align_result(s.result, s.align);

    always_comb begin
        next_s = s;
        // Bus answer one cycle into the access phase
        next_s.pready  = apb_setup;
        next_s.pslverr = apb_setup & ~hit;
        next_s.prdata  = apb_setup ? read_word(s, paddr_i) : '0;
        if (apb_acc && pwrite_i) begin
            unique case (paddr_i)
                OFS_INPUT_SELECT: begin
                    next_s.ref_w = pwdata_i[IS_REF_LSB +: REF_W];
                    next_s.align = pwdata_i[IS_ALIGN_BIT];
                    next_s.ch_w  = pwdata_i[IS_CH_LSB +: CH_W];
                end
                OFS_CONTROL_A: begin
                    next_s.enable    = pwdata_i[CA_EN_BIT];
                    next_s.auto_trig = pwdata_i[CA_AUTO_BIT];
                    next_s.ps        = pwdata_i[CA_PS_LSB +: PS_W];
                    if (pwdata_i[CA_FLAG_BIT]) begin
                        next_s.flag = 1'b0;
                    end
                end
                OFS_CONTROL_B: next_s.tsel = pwdata_i[CB_TS_LSB +: TS_W];
                default: ;
            endcase
        end
        if (apb_acc && !pwrite_i && paddr_i == OFS_RESULT_LOW) begin
            next_s.lock = 1'b1;
        end
        if (apb_acc && !pwrite_i && paddr_i == OFS_RESULT_HIGH) begin
            next_s.lock = 1'b0;
        end
        // Conversion sequencing
        unique case (s.state)
            conv_idle: begin
                if (next_s.enable && (sw_start || presc_restart)) begin
                    next_s.state = conv_run;
                    next_s.left  = s.first ? FIRST_CYCLES : NORMAL_CYCLES;
                    next_s.first = 1'b0;
                end
            end
            conv_run: begin
                if (done) begin
                    next_s.flag = 1'b1;
                    if (!s.lock && next_s.enable) begin
                        next_s.result = result_data_i;
                    end
                    if (free_run) begin
                        next_s.left = NORMAL_CYCLES;
                    end else begin
                        next_s.state = conv_idle;
                    end
                end else if (tick) begin
                    next_s.left = s.left - 5'h01;
                end
            end
        endcase
        if (!next_s.enable) begin
            next_s.state = conv_idle;
            next_s.first = 1'b1;
        end
        // Selections follow the written values only while enabled and not mid-run
        if (s.enable && (s.state == conv_idle || done)) begin
            next_s.app_ref = s.ref_w;
            next_s.app_ch  = s.ch_w;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s       <= '0;
            s.first <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_o       = s.prdata;
    assign pready_o       = s.pready;
    assign pslverr_o      = s.pslverr;
    assign converter_on_o = s.enable;
    assign converting_o   = s.state == conv_run;
    assign channel_o      = s.app_ch;
    assign reference_o    = s.app_ref;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic rd_ctrl_a;
    logic rd_low;
    assign rd_ctrl_a = apb_setup & ~pwrite_i & (paddr_i == OFS_CONTROL_A);
    assign rd_low    = apb_setup & ~pwrite_i & (paddr_i == OFS_RESULT_LOW);

    property p_start_reads_busy;
        rd_ctrl_a && converting_o |=> pready_o && prdata_o[CA_START_BIT];
    endproperty
    a_start_reads_busy: assert property (p_start_reads_busy)
        else $error("start bit not one during conversion");

    property p_locked_result_kept;
        done && s.lock |=> $stable(s.result) && s.flag;
    endproperty
    a_locked_result_kept: assert property (p_locked_result_kept)
        else $error("blocked result changed");

    logic conversion_flag_set;
    assign conversion_flag_set = s.flag;
    property p_flag_on_done;
        done |=> conversion_flag_set;
    endproperty
    a_flag_on_done: assert property (p_flag_on_done)
        else $error("done flag not set on completion");

    property p_single_clears_start;
        done && !free_run && s.enable |=> !converting_o && s.result == (
            ($past(s.lock) || !$past(next_s.enable)) ? $past(s.result) : $past(result_data_i));
    endproperty
    a_single_clears_start: assert property (p_single_clears_start)
        else $error("single conversion did not end cleanly");

    property p_free_run_continues;
        done && free_run && next_s.enable |=> converting_o && s.left == NORMAL_CYCLES;
    endproperty
    a_free_run_continues: assert property (p_free_run_continues)
        else $error("free running did not restart");

    property p_abort_on_disable;
        converting_o && !next_s.enable |=> !converting_o && $stable(s.result);
    endproperty
    a_abort_on_disable: assert property (p_abort_on_disable)
        else $error("disable did not abort");

    property p_channel_locked;
        converting_o && !done |=> $stable(channel_o) && $stable(reference_o);
    endproperty
    a_channel_locked: assert property (p_channel_locked)
        else $error("selection moved during conversion");

    property p_disabled_no_apply;
        !converter_on_o |=> $stable(channel_o);
    endproperty
    a_disabled_no_apply: assert property (p_disabled_no_apply)
        else $error("selection applied while disabled");

    property p_first_is_long;
        !converting_o && s.first ##1 converting_o |-> s.left == FIRST_CYCLES;
    endproperty
    a_first_is_long: assert property (p_first_is_long)
        else $error("first conversion length wrong");

    property p_presc_held;
        !converter_on_o ##1 !converter_on_o |-> !tick;
    endproperty
    a_presc_held: assert property (p_presc_held)
        else $error("prescaler ticked while disabled");

    property p_low_read_locks;
        rd_low ##1 apb_acc |=> s.lock;
    endproperty
    a_low_read_locks: assert property (p_low_read_locks)
        else $error("low byte read did not lock");

    c_free_run: cover property (done && free_run);
    c_lost_result: cover property (done && s.lock);
    c_abort: cover property (converting_o && !next_s.enable);
    c_trigger_start: cover property (presc_restart && s.enable);

endmodule : sar_converter_control

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
    import sar_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Signals and design
    logic                clk_i          = 1'b0;
    logic                reset_n_i      = 1'b0;
    logic                psel_i         = 1'b0;
    logic                penable_i      = 1'b0;
    logic                pwrite_i       = 1'b0;
    logic [ADDR_W-1:0]   paddr_i        = 8'h00;
    logic [DATA_W-1:0]   pwdata_i       = 32'h0;
    logic [7:1]          trigger_i      = 7'h00;
    logic [RESULT_W-1:0] result_data_i  = 10'h000;
    logic [DATA_W-1:0]   prdata_o;
    logic                pready_o;
    logic                pslverr_o;
    logic                converter_on_o;
    logic                converting_o;
    logic [CH_W-1:0]     channel_o;
    logic [REF_W-1:0]    reference_o;
    int                  n_fail         = 0;
    int                  cmp_count      = 0;
    int                  cyc            = 0;

    always #5 clk_i = ~clk_i;

    sar_converter_control uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .trigger_i(trigger_i), .result_data_i(result_data_i),
        .converter_on_o(converter_on_o), .converting_o(converting_o),
        .channel_o(channel_o), .reference_o(reference_o));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // One APB transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check(32'(e), 32'(experr));
    endtask : rd

    // Cycles from now until a running conversion ends
    task automatic wait_done(output int n);
        bit seen;
        n = 0;
        seen = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (converting_o === 1'b1) seen = 1;
        end while (!(seen && converting_o === 1'b0) && n < 2000);
    endtask : wait_done

    task automatic wait_busy;
        int n;
        n = 0;
        while (converting_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(converting_o), 32'h1);
    endtask : wait_busy

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rd(OFS_INPUT_SELECT, 32'h0);
        rd(OFS_CONTROL_A, 32'h0);
        rd(OFS_CONTROL_B, 32'h0);
        rd(OFS_RESULT_LOW, 32'h0);
        rd(OFS_RESULT_HIGH, 32'h0);
        rd(8'h14, 32'h0, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_enable;
        wr(OFS_INPUT_SELECT, 32'hCE);
        wr(OFS_CONTROL_A, 32'h40);
        tick(3);
        check(32'(channel_o), 32'h0);
        check(32'(reference_o), 32'h0);
        check(32'(converting_o), 32'h0);
        wr(OFS_CONTROL_A, 32'h80);
        tick(2);
        check(32'(converter_on_o), 32'h1);
        check(32'(channel_o), 32'(CH_BANDGAP));
        check(32'(reference_o), 32'(REF_INTERNAL));
        for (int c = 0; c < 10; c++) begin
            wr(OFS_INPUT_SELECT, 32'h40 | 32'((c < 8) ? c : c + 6));
            tick(2);
            check(32'(channel_o), 32'((c < 8) ? c : c + 6));
            check(32'(reference_o), 32'(REF_SUPPLY));
        end
        wr(OFS_INPUT_SELECT, 32'h45);
        $display("test enable done");
    endtask : t_enable

    task automatic t_single;
        int n;
        result_data_i <= 10'h2A5;
        wr(OFS_CONTROL_A, 32'hC0);
        wait_done(n);
        check(32'(n >= 46 && n <= 56), 32'h1);
        rd(OFS_CONTROL_A, 32'h90);
        rd(OFS_RESULT_LOW, 32'hA5);
        rd(OFS_RESULT_HIGH, 32'h02);
        wr(OFS_INPUT_SELECT, 32'h65);
        result_data_i <= 10'h1C6;
        wr(OFS_CONTROL_A, 32'hD0);
        rd(OFS_CONTROL_A, 32'hC0);
        wait_done(n);
        check(32'(n >= 14 && n <= 28), 32'h1);
        rd(OFS_RESULT_LOW, 32'h80);
        rd(OFS_RESULT_HIGH, 32'h71);
        $display("test single done");
    endtask : t_single

    task automatic t_lock;
        int n;
        wr(OFS_INPUT_SELECT, 32'h45);
        wr(OFS_CONTROL_A, 32'h90);
        rd(OFS_RESULT_LOW, 32'hC6);
        result_data_i <= 10'h0F0;
        wr(OFS_CONTROL_A, 32'hC0);
        wait_done(n);
        rd(OFS_CONTROL_A, 32'h90);
        rd(OFS_RESULT_HIGH, 32'h01);
        wr(OFS_CONTROL_A, 32'hD2);
        wait_done(n);
        check(32'(n >= 48 && n <= 56), 32'h1);
        rd(OFS_RESULT_LOW, 32'hF0);
        rd(OFS_RESULT_HIGH, 32'h00);
        $display("test lock done");
    endtask : t_lock

    task automatic t_chan;
        int n;
        wr(OFS_CONTROL_A, 32'hC0);
        wr(OFS_INPUT_SELECT, 32'h42);
        check(32'(channel_o), 32'h5);
        wait_done(n);
        tick(2);
        check(32'(channel_o), 32'h2);
        $display("test channel done");
    endtask : t_chan

    task automatic t_trig;
        int n;
        wr(OFS_CONTROL_B, 32'h1);
        wr(OFS_CONTROL_A, 32'hB0);
        @(posedge clk_i);
        trigger_i[1] <= 1'b1;
        wait_busy();
        tick(4);
        trigger_i[1] <= 1'b0;
        tick(2);
        trigger_i[1] <= 1'b1;
        wait_done(n);
        n = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (converting_o !== 1'b0) n++;
        end
        check(32'(n), 32'h0);
        rd(OFS_CONTROL_A, 32'hB0);
        trigger_i <= 7'h04;
        n = 0;
        repeat (20) begin
            @(posedge clk_i);
            if (converting_o !== 1'b0) n++;
        end
        check(32'(n), 32'h0);
        trigger_i <= 7'h00;
        $display("test trigger done");
    endtask : t_trig

    task automatic t_free;
        int n;
        wr(OFS_CONTROL_A, 32'h90);
        wr(OFS_CONTROL_B, 32'h0);
        tick(4);
        check(32'(converting_o), 32'h0);
        wr(OFS_CONTROL_A, 32'hF0);
        wait_busy();
        n = 0;
        repeat (90) begin
            @(posedge clk_i);
            if (converting_o !== 1'b1) n++;
        end
        check(32'(n), 32'h0);
        rd(OFS_CONTROL_A, 32'hF0);
        $display("test free running done");
    endtask : t_free

    task automatic t_abort;
        int n;
        wr(OFS_CONTROL_A, 32'h90);
        wait_done(n);
        result_data_i <= 10'h155;
        wr(OFS_CONTROL_A, 32'hC0);
        tick(6);
        wr(OFS_CONTROL_A, 32'h00);
        tick(1);
        check(32'(converting_o), 32'h0);
        check(32'(converter_on_o), 32'h0);
        rd(OFS_CONTROL_A, 32'h10);
        rd(OFS_RESULT_LOW, 32'hF0);
        rd(OFS_RESULT_HIGH, 32'h00);
        $display("test abort done");
    endtask : t_abort

    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_enable();
        t_single();
        t_lock();
        t_chan();
        t_trig();
        t_free();
        t_abort();
        finish_test();
    end

endmodule : tb
